// File: src/srr_pkg.sv
// shared constants and types for the scattered resolver readout
// assumes a 250 MHz system clock and 12-bit unsigned converter codes
package srr_pkg;

    // ****************************************
    // widths and timing
    // ****************************************
    localparam int ADC_W = 12;
    localparam int SUM_W = ADC_W + 4;
    localparam int ANG_W = 16;
    localparam int SQ_W = 2 * SUM_W;
    localparam int CLK_PERIOD_PS = 4000;
    // routing settle time after a crossbar change, least time
    localparam int SETTLE_NS = 2000;
    localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CORDIC_ITER = 15;
    localparam logic [ANG_W-1:0] ANG_PI = 16'h8000;
    localparam logic [ANG_W-1:0] ANG_ZERO = 16'h0000;

    // ****************************************
    // sequencer types
    // ****************************************
    typedef enum logic [1:0] {
        PH_CAL = 2'b00,
        PH_DIR = 2'b01,
        PH_SWP = 2'b10
    } srr_phase_t;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_ARM = 2'b01,
        ST_WAIT = 2'b10
    } srr_step_t;

    // arctan(2^-i), full turn = 2^16
    function automatic logic [ANG_W-1:0] srr_atan_step(input logic [3:0] i);
        case (i)
            4'h0: srr_atan_step = 16'h2000;
            4'h1: srr_atan_step = 16'h12E4;
            4'h2: srr_atan_step = 16'h09FB;
            4'h3: srr_atan_step = 16'h0511;
            4'h4: srr_atan_step = 16'h028B;
            4'h5: srr_atan_step = 16'h0146;
            4'h6: srr_atan_step = 16'h00A3;
            4'h7: srr_atan_step = 16'h0051;
            4'h8: srr_atan_step = 16'h0029;
            4'h9: srr_atan_step = 16'h0014;
            4'hA: srr_atan_step = 16'h000A;
            4'hB: srr_atan_step = 16'h0005;
            4'hC: srr_atan_step = 16'h0003;
            4'hD: srr_atan_step = 16'h0001;
            4'hE: srr_atan_step = 16'h0001;
            default: srr_atan_step = 16'h0000;
        endcase
    endfunction : srr_atan_step

endpackage : srr_pkg

// File: src/srr_atan2.sv
// iterative four-quadrant arctangent, vectoring cordic
// assumes start_i is not raised while busy_o is high; such a start is ignored
`timescale 1ns/10ps
module srr_atan2
    import srr_pkg::*;
#(
    parameter int IN_W = SUM_W,
    parameter int ITER = CORDIC_ITER
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic start_i,
    input wire logic signed [IN_W-1:0] y_i,
    input wire logic signed [IN_W-1:0] x_i,
    output logic busy_o,
    output logic done_o,
    output logic [ANG_W-1:0] angle_o
);

    // guard bits keep shift truncation well below one angle step
    localparam int GRD = 4;
    localparam int XW = IN_W + 2 + GRD;

    if (ITER < 2 || ITER > 16) begin : g_chk
        $error("srr_atan2: ITER out of range");
    end

    logic signed [XW-1:0] x_q, x_d, y_q, y_d;
    logic [ANG_W-1:0] z_q, z_d;
    logic [3:0] i_q, i_d;
    logic busy_q, busy_d, done_q, done_d;

    always_comb begin
        logic signed [XW-1:0] xs, ys;
        xs = {{2{x_i[IN_W-1]}}, x_i, {GRD{1'b0}}};
        ys = {{2{y_i[IN_W-1]}}, y_i, {GRD{1'b0}}};
        x_d = x_q;
        y_d = y_q;
        z_d = z_q;
        i_d = i_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (start_i && !busy_q) begin
            // left half plane: pre-rotate by pi so vectoring stays in range
            if (xs < 0) begin
                x_d = -xs;
                y_d = -ys;
                z_d = ANG_PI;
            end else begin
                x_d = xs;
                y_d = ys;
                z_d = ANG_ZERO;
            end
            i_d = 4'h0;
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (y_q >= 0) begin
                x_d = x_q + (y_q >>> i_q);
                y_d = y_q - (x_q >>> i_q);
                z_d = z_q + srr_atan_step(i_q);
            end else begin
                x_d = x_q - (y_q >>> i_q);
                y_d = y_q + (x_q >>> i_q);
                z_d = z_q - srr_atan_step(i_q);
            end
            i_d = i_q + 4'h1;
            if (i_q == 4'(ITER - 1)) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            x_q <= '0;
            y_q <= '0;
            z_q <= ANG_ZERO;
            i_q <= 4'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            x_q <= x_d;
            y_q <= y_d;
            z_q <= z_d;
            i_q <= i_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy_o = busy_q;
    assign done_o = done_q;
    assign angle_o = z_q;

endmodule : srr_atan2

// File: src/srr_readout.sv
// scattered resolver readout: crossbar sequencer, offset removal, diagnostics, angle
// assumes converter answers each sample_req_o with one conv_done_i pulse,
// both channels held on separate sample-and-hold paths
//
// Function
// [RULE1] cycle through offset calibration, direct sampling, swapped sampling in order
// [RULE2] calibration: inhibit crossbar, store each channel result as its offset
// [RULE3] direct: first input carries cosine via A, second sine via B
// [RULE4] swapped: swap select routes sine to A, cosine to B; capture both
// [RULE5] routing changes while running without stalling the angle calculation
// [RULE6] sine = B direct + A swapped; cosine = A direct + B swapped
// [RULE7] subtract both stored offsets from summed sine and cosine terms
// [RULE8] angle is four-quadrant arctangent of sine over cosine, full plus/minus pi
// [RULE9] calibration by default only after start-up; configurable per cycle
// [RULE10] after start-up calibration alternate only direct and swapped phases
// [RULE11] phase switching and sampling much faster than resolver signal bandwidth
// [RULE12] check both offsets against configurable bounds; flag failure otherwise
// [RULE13] flag failure when direct and swapped samples differ beyond a maximum
// [RULE14] check sine and cosine amplitudes against bounds; flag failure otherwise
// [RULE15] on failure name the faulty channel; optionally run on healthy one (a RULE13 mismatch raises only diag_fail_o, with no channel flag)
// [RULE16] drive a crossbar inhibit output and a separate swap select output
// [RULE17] sample at excitation peak, once per excitation period
// [RULE18] sample both channels together so results share one instant
// [RULE19] wait a configurable settling interval after each routing change
// [RULE20] result strobe only after a direct and swapped pair is combined
`timescale 1ns/10ps
module srr_readout
    import srr_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYC
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic exc_peak_i,
    input wire logic conv_done_i,
    input wire logic [ADC_W-1:0] first_converter_input_i,
    input wire logic [ADC_W-1:0] second_converter_input_i,
    input wire logic recal_each_cycle_i,
    input wire logic limp_enable_i,
    input wire logic diag_clear_i,
    input wire logic [ADC_W-1:0] offset_min_i,
    input wire logic [ADC_W-1:0] offset_max_i,
    input wire logic [ADC_W-1:0] diff_max_i,
    input wire logic [SQ_W-1:0] amp_sq_min_i,
    input wire logic [SQ_W-1:0] amp_sq_max_i,
    output logic crossbar_inhibit_o,
    output logic crossbar_swap_o,
    output logic sample_req_o,
    output logic [ANG_W-1:0] angle_o,
    output logic angle_valid_o,
    output logic diag_fail_o,
    output logic fault_chan_a_o,
    output logic fault_chan_b_o,
    output logic limp_mode_o
);

    localparam int CW = $clog2(SETTLE + 1);

    if (SETTLE < 1) begin : g_chk
        $error("srr_readout: SETTLE must be at least one cycle");
    end

    function automatic logic signed [SUM_W-1:0] sx(input logic [ADC_W-1:0] v);
        sx = $signed({{(SUM_W - ADC_W){1'b0}}, v});
    endfunction : sx

    function automatic logic [SUM_W-1:0] absdiff(input logic [ADC_W-1:0] a,
                                                 input logic [ADC_W-1:0] b);
        logic signed [SUM_W-1:0] d;
        d = sx(a) - sx(b);
        absdiff = (d < 0) ? SUM_W'(-d) : SUM_W'(d);
    endfunction : absdiff

    // ****************************************
    // phase sequencer
    // ****************************************
    srr_phase_t phase_q, phase_d;
    srr_step_t step_q, step_d;
    logic [CW-1:0] settle_q, settle_d;
    logic [ADC_W-1:0] off_a_q, off_a_d, off_b_q, off_b_d;
    logic [ADC_W-1:0] a_dir_q, a_dir_d, b_dir_q, b_dir_d;
    logic [ADC_W-1:0] a_swp_q, a_swp_d, b_swp_q, b_swp_d;
    logic inh_q, inh_d, swap_q, swap_d, req_q, req_d, calc_q, calc_d;

    always_comb begin
        phase_d = phase_q;
        step_d = step_q;
        settle_d = settle_q;
        off_a_d = off_a_q;
        off_b_d = off_b_q;
        a_dir_d = a_dir_q;
        b_dir_d = b_dir_q;
        a_swp_d = a_swp_q;
        b_swp_d = b_swp_q;
        req_d = 1'b0;
        calc_d = 1'b0;
        case (step_q)
            ST_SETTLE: begin
                if (settle_q == '0) begin
                    step_d = ST_ARM;
                end else begin
                    settle_d = settle_q - CW'(1); // RULE19
                end
            end
            ST_ARM: begin
                // one request per peak; phases must outpace the resolver // RULE11
                if (exc_peak_i) begin
                    req_d = 1'b1; // RULE17 RULE18
                    step_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (conv_done_i) begin
                    case (phase_q)
                        PH_CAL: begin
                            off_a_d = first_converter_input_i; // RULE2
                            off_b_d = second_converter_input_i; // RULE2
                            phase_d = PH_DIR; // RULE1
                        end
                        PH_DIR: begin
                            a_dir_d = first_converter_input_i; // RULE3
                            b_dir_d = second_converter_input_i; // RULE3
                            phase_d = PH_SWP; // RULE1
                        end
                        default: begin
                            a_swp_d = first_converter_input_i; // RULE4
                            b_swp_d = second_converter_input_i; // RULE4
                            calc_d = 1'b1;
                            // start-up calibration only unless asked // RULE9 RULE10
                            phase_d = recal_each_cycle_i ? PH_CAL : PH_DIR;
                        end
                    endcase
                    step_d = ST_SETTLE;
                    settle_d = CW'(SETTLE - 1); // RULE19
                end
            end
            default: begin
                step_d = ST_SETTLE;
            end
        endcase
        inh_d = (phase_d == PH_CAL); // RULE2 RULE16
        swap_d = (phase_d == PH_SWP); // RULE4 RULE16
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase_q <= PH_CAL;
            step_q <= ST_SETTLE;
            settle_q <= CW'(SETTLE - 1);
            off_a_q <= '0;
            off_b_q <= '0;
            a_dir_q <= '0;
            b_dir_q <= '0;
            a_swp_q <= '0;
            b_swp_q <= '0;
            inh_q <= 1'b1;
            swap_q <= 1'b0;
            req_q <= 1'b0;
            calc_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            step_q <= step_d;
            settle_q <= settle_d;
            off_a_q <= off_a_d;
            off_b_q <= off_b_d;
            a_dir_q <= a_dir_d;
            b_dir_q <= b_dir_d;
            a_swp_q <= a_swp_d;
            b_swp_q <= b_swp_d;
            inh_q <= inh_d;
            swap_q <= swap_d;
            req_q <= req_d;
            calc_q <= calc_d;
        end
    end

    // ****************************************
    // combine, diagnose, angle
    // ****************************************
    logic signed [SUM_W-1:0] sin_t, cos_t, ca_c, ca_s, cb_s, cb_c;
    logic [SQ_W-1:0] amp_a, amp_b;
    logic bad_a, bad_b, bad_diff, use_b, use_a;
    logic signed [SUM_W-1:0] sin_go_q, sin_go_d, cos_go_q, cos_go_d;
    logic go_q, go_d;
    logic fa_q, fa_d, fb_q, fb_d, fail_q, fail_d, limp_q, limp_d;
    logic [ANG_W-1:0] ang_q, ang_d;
    logic val_q, val_d;
    logic cdc_done;
    logic [ANG_W-1:0] cdc_ang;

    always_comb begin
        ca_c = sx(a_dir_q) - sx(off_a_q);
        ca_s = sx(a_swp_q) - sx(off_a_q);
        cb_s = sx(b_dir_q) - sx(off_b_q);
        cb_c = sx(b_swp_q) - sx(off_b_q);
        amp_a = SQ_W'(ca_c) * SQ_W'(ca_c) + SQ_W'(ca_s) * SQ_W'(ca_s);
        amp_b = SQ_W'(cb_s) * SQ_W'(cb_s) + SQ_W'(cb_c) * SQ_W'(cb_c);
        bad_a = (off_a_q < offset_min_i) || (off_a_q > offset_max_i) // RULE12
            || (amp_a < amp_sq_min_i) || (amp_a > amp_sq_max_i); // RULE14
        bad_b = (off_b_q < offset_min_i) || (off_b_q > offset_max_i) // RULE12
            || (amp_b < amp_sq_min_i) || (amp_b > amp_sq_max_i); // RULE14
        bad_diff = (absdiff(a_dir_q, b_swp_q) > {4'h0, diff_max_i}) // RULE13
            || (absdiff(b_dir_q, a_swp_q) > {4'h0, diff_max_i}); // RULE13
        // set wins over a clear in the same cycle
        fa_d = (fa_q && !diag_clear_i) || (calc_q && bad_a); // RULE15
        fb_d = (fb_q && !diag_clear_i) || (calc_q && bad_b); // RULE15
        fail_d = (fail_q && !diag_clear_i) || (calc_q && (bad_a || bad_b || bad_diff));
        // both channels down leaves nothing healthy, so stay on the full pair
        use_b = limp_enable_i && fa_d && !fb_d; // RULE15
        use_a = limp_enable_i && fb_d && !fa_d; // RULE15
        limp_d = use_a || use_b;
        if (use_b) begin
            sin_t = cb_s <<< 1;
            cos_t = cb_c <<< 1;
        end else if (use_a) begin
            sin_t = ca_s <<< 1;
            cos_t = ca_c <<< 1;
        end else begin
            sin_t = sx(b_dir_q) + sx(a_swp_q) - sx(off_a_q) - sx(off_b_q); // RULE6 RULE7
            cos_t = sx(a_dir_q) + sx(b_swp_q) - sx(off_a_q) - sx(off_b_q); // RULE6 RULE7
        end
        go_d = calc_q;
        sin_go_d = calc_q ? sin_t : sin_go_q;
        cos_go_d = calc_q ? cos_t : cos_go_q;
        ang_d = cdc_done ? cdc_ang : ang_q;
        val_d = cdc_done; // RULE20
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sin_go_q <= '0;
            cos_go_q <= '0;
            go_q <= 1'b0;
            fa_q <= 1'b0;
            fb_q <= 1'b0;
            fail_q <= 1'b0;
            limp_q <= 1'b0;
            ang_q <= ANG_ZERO;
            val_q <= 1'b0;
        end else begin
            sin_go_q <= sin_go_d;
            cos_go_q <= cos_go_d;
            go_q <= go_d;
            fa_q <= fa_d;
            fb_q <= fb_d;
            fail_q <= fail_d;
            limp_q <= limp_d;
            ang_q <= ang_d;
            val_q <= val_d;
        end
    end

    // runs beside the sequencer, so routing keeps moving during the math // RULE5
    srr_atan2 #(
        .IN_W(SUM_W),
        .ITER(CORDIC_ITER)
    ) u_atan2 (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .start_i(go_q), // RULE8
        .y_i(sin_go_q),
        .x_i(cos_go_q),
        .busy_o(),
        .done_o(cdc_done),
        .angle_o(cdc_ang)
    );

    assign crossbar_inhibit_o = inh_q;
    assign crossbar_swap_o = swap_q;
    assign sample_req_o = req_q;
    assign angle_o = ang_q;
    assign angle_valid_o = val_q;
    assign diag_fail_o = fail_q;
    assign fault_chan_a_o = fa_q;
    assign fault_chan_b_o = fb_q;
    assign limp_mode_o = limp_q;

endmodule : srr_readout

// File: tb/srr_readout_props.sv
// concurrent checks on the resolver readout's top-level ports
// assumes one clock domain and an active-high asynchronous reset
`timescale 1ns/10ps
module srr_readout_props
    import srr_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYC
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic exc_peak_i,
    input wire logic conv_done_i,
    input wire logic recal_each_cycle_i,
    input wire logic diag_clear_i,
    input wire logic crossbar_inhibit_o,
    input wire logic crossbar_swap_o,
    input wire logic sample_req_o,
    input wire logic angle_valid_o,
    input wire logic diag_fail_o,
    input wire logic fault_chan_a_o,
    input wire logic fault_chan_b_o
);
    logic [1:0] route_q;
    logic [1:0] route_d;
    logic [15:0] quiet_q;
    logic [15:0] quiet_d;
    logic swp_take;
    assign swp_take = conv_done_i && crossbar_swap_o;
    // cycles since routing last moved, saturating
    always_comb begin
        route_d = {crossbar_inhibit_o, crossbar_swap_o};
        quiet_d = quiet_q + {15'h0000, quiet_q != 16'hFFFF};
        if (route_d != route_q) begin
            quiet_d = 16'h0000;
        end
    end
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            route_q <= 2'h2;
            quiet_q <= 16'(SETTLE);
        end else begin
            route_q <= route_d;
            quiet_q <= quiet_d;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    req_on_peak_a: assert property (sample_req_o |-> $past(exc_peak_i))
        else $error("request without peak");
    settle_wait_a: assert property (sample_req_o |-> quiet_q >= SETTLE)
        else $error("request inside settle time");
    route_excl_a: assert property (!(crossbar_inhibit_o && crossbar_swap_o))
        else $error("inhibit and swap together");
    route_cause_a: assert property ($changed(route_d) |-> $past(conv_done_i))
        else $error("routing moved without capture");
    dir_to_swap_a: assert property ($rose(crossbar_swap_o) |-> !$past(crossbar_inhibit_o))
        else $error("swap entered from calibration");
    recal_only_a: assert property ($rose(crossbar_inhibit_o) |-> $past(recal_each_cycle_i))
        else $error("calibration repeated unasked");
    valid_time_a: assert property (swp_take |-> ##19 angle_valid_o)
        else $error("angle late");
    valid_cause_a: assert property (angle_valid_o |-> $past(swp_take, 19))
        else $error("angle without pair");
    flag_time_a: assert property ($rose(diag_fail_o) |-> $past(swp_take, 2))
        else $error("failure flag off pair");
    fault_named_a: assert property ($rose(fault_chan_a_o) |-> diag_fail_o)
        else $error("channel fault without failure");
    sticky_fail_a: assert property ($fell(diag_fail_o) |-> $past(diag_clear_i))
        else $error("failure dropped unasked");
endmodule : srr_readout_props
bind srr_readout srr_readout_props #(.SETTLE(SETTLE)) props_u (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .exc_peak_i(exc_peak_i),
    .conv_done_i(conv_done_i), .recal_each_cycle_i(recal_each_cycle_i),
    .diag_clear_i(diag_clear_i), .crossbar_inhibit_o(crossbar_inhibit_o),
    .crossbar_swap_o(crossbar_swap_o), .sample_req_o(sample_req_o),
    .angle_valid_o(angle_valid_o), .diag_fail_o(diag_fail_o),
    .fault_chan_a_o(fault_chan_a_o), .fault_chan_b_o(fault_chan_b_o));

// File: tb/srr_front_model.sv
// stand-in for crossbar, two amplifier channels, converter and peak marker
// drives at falling edges; gains differ on purpose to show imbalance
`timescale 1ns/10ps
module srr_front_model
    import srr_pkg::*;
#(
    parameter int GAIN_A = 16,
    parameter int GAIN_B = 15
) (
    input wire logic clock_i,
    input wire logic inhibit_i,
    input wire logic swap_i,
    input wire logic req_i,
    input wire logic signed [ADC_W-1:0] sin_i,
    input wire logic signed [ADC_W-1:0] cos_i,
    input wire logic [ADC_W-1:0] off_a_i,
    input wire logic [ADC_W-1:0] off_b_i,
    output logic peak_o,
    output logic done_o,
    output logic [ADC_W-1:0] a_o,
    output logic [ADC_W-1:0] b_o
);
    int tick = 0;
    int wait_n = 0;
    logic slow = 1'b0;
    logic [ADC_W-1:0] ha;
    logic [ADC_W-1:0] hb;
    function automatic logic [ADC_W-1:0] chan(input logic [ADC_W-1:0] off, input int v,
                                              input int g);
        return ADC_W'(int'(off) + v * g / 16);
    endfunction : chan
    initial begin
        {peak_o, done_o, a_o, b_o} = '0;
    end
    always @(negedge clock_i) begin
        tick = (tick + 1) % 40;
        peak_o = (tick == 0);
        done_o = 1'b0;
        // results are not held past their strobe
        a_o = ~a_o;
        b_o = ~b_o;
        if (wait_n > 0) begin
            wait_n--;
            if (wait_n == 0) begin
                done_o = 1'b1;
                a_o = ha;
                b_o = hb;
            end
        end
        if (req_i) begin
            ha = chan(off_a_i, swap_i ? sin_i : cos_i, inhibit_i ? 0 : GAIN_A);
            hb = chan(off_b_i, swap_i ? cos_i : sin_i, inhibit_i ? 0 : GAIN_B);
            wait_n = slow ? 7 : 1;
            slow = !slow;
        end
    end
endmodule : srr_front_model

// File: tb/srr_readout_tb.sv
// self-checking bench for the resolver readout, small settle count
// front model answers requests; bench drives settings at falling edges
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module srr_readout_tb
    import srr_pkg::*;
;
    logic clock_i = 1'b0, sys_rst_i = 1'b1, peak, done, recal, limp_en, clr;
    logic crossbar_inhibit, swp, req, valid, dfail, fa, fb, limp;
    logic [ADC_W-1:0] a_code, b_code, omin, omax, dmax, off_a, off_b;
    logic [SQ_W-1:0] amin, amax;
    logic [ANG_W-1:0] angle;
    logic efa = 0, efb = 0, edg = 0;
    int sin_v, cos_v, seed = 32'h70A6, n_fail = 0, check_count = 0, ph = 0, oa, ob, ad, bd;
    logic [ANG_W+3:0] q[$];
    initial begin
        forever #2 clock_i = ~clock_i;
    end
    srr_readout #(.SETTLE(4)) dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .exc_peak_i(peak), .conv_done_i(done), .first_converter_input_i(a_code),
        .second_converter_input_i(b_code), .recal_each_cycle_i(recal),
        .limp_enable_i(limp_en), .diag_clear_i(clr), .offset_min_i(omin), .offset_max_i(omax),
        .diff_max_i(dmax), .amp_sq_min_i(amin), .amp_sq_max_i(amax),
        .crossbar_inhibit_o(crossbar_inhibit), .crossbar_swap_o(swp), .sample_req_o(req), .angle_o(angle),
        .angle_valid_o(valid), .diag_fail_o(dfail), .fault_chan_a_o(fa),
        .fault_chan_b_o(fb), .limp_mode_o(limp));
    srr_front_model fm_u (.clock_i(clock_i), .inhibit_i(crossbar_inhibit), .swap_i(swp), .req_i(req),
        .sin_i(12'(sin_v)), .cos_i(12'(cos_v)), .off_a_i(off_a), .off_b_i(off_b),
        .peak_o(peak), .done_o(done), .a_o(a_code), .b_o(b_code));
    task automatic pair();
        int sa = a_code, sb = b_code, pa, pb, s, c;
        logic lm;
        real r;
        pa = (ad - oa) ** 2 + (sa - oa) ** 2;
        pb = (bd - ob) ** 2 + (sb - ob) ** 2;
        efa |= oa < int'(omin) || oa > int'(omax) || pa < int'(amin) || pa > int'(amax);
        efb |= ob < int'(omin) || ob > int'(omax) || pb < int'(amin) || pb > int'(amax);
        edg |= efa | efb | (ad - sb > int'(dmax)) | (sb - ad > int'(dmax));
        edg |= (bd - sa > int'(dmax)) | (sa - bd > int'(dmax));
        lm = limp_en && (efa != efb);
        s = bd + sa - oa - ob;
        c = ad + sb - oa - ob;
        if (lm && efa) begin
            s = 2 * (bd - ob);
            c = 2 * (sb - ob);
        end else if (lm) begin
            s = 2 * (sa - oa);
            c = 2 * (ad - oa);
        end
        r = $atan2(s, c) * 32768.0 / 3.14159265358979;
        q.push_back({16'($rtoi(r)), edg, efa, efb, lm});
        // angle moves only between pairs
        r = ($random(seed) & 16'hFFFF) * 3.14159265358979 / 32768.0;
        sin_v = $rtoi(800.0 * $sin(r));
        cos_v = (q.size() == 1) ? -800 : $rtoi(800.0 * $cos(r));
    endtask : pair
    always @(posedge clock_i) begin
        #1;
        if (!sys_rst_i) begin
            if (req) begin
                `CHK({crossbar_inhibit, swp}, (ph == 0) ? 2'h2 : ((ph == 2) ? 2'h1 : 2'h0))
            end
            if (clr) begin
                {efa, efb, edg} = 3'h0;
            end
            if (done) begin
                if (ph == 0) begin
                    oa = a_code;
                    ob = b_code;
                end else if (ph == 1) begin
                    ad = a_code;
                    bd = b_code;
                end else begin
                    pair();
                end
                ph = (ph == 2) ? (recal ? 0 : 1) : ph + 1;
            end
            if (valid && q.size() == 0) begin
                `CHK(1'b1, 1'b0)
            end else if (valid) begin
                `CHK(16'(angle - q[0][19:4]) + 16'h0010 < 16'h0020, 1'b1)
                `CHK({dfail, fa, fb, limp}, q.pop_front() & 20'h0000F)
            end
        end
    end
    task automatic run(input string name, input int n);
        int got = 0;
        for (int k = 0; k < 500 * n && got < n; k++) begin
            @(negedge clock_i);
            got += (valid === 1'b1);
        end
        `CHK(got, n)
        $display("test %s done", name);
    endtask : run
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (40000) @(posedge clock_i);
        n_fail++;
        conclude();
    end
    initial begin
        {recal, clr, limp_en, sin_v, cos_v} = {3'h1, 32'd0, 32'd800};
        {omin, omax, dmax, amin, amax} = {36'h700900FFF, 64'h7FFFFFFF};
        {off_a, off_b} = 24'h8007C0;
        repeat (16) @(negedge clock_i);
        `CHK({crossbar_inhibit, swp, req, valid, dfail, fa, fb, limp, angle}, 24'h800000)
        sys_rst_i = 1'b0;
        run("nominal", 8);
        {recal, off_a, off_b} = {1'b1, 24'h8407A0};
        run("recal", 4);
        recal = 1'b0;
        run("alternate", 3);
        {recal, off_a} = {1'b1, 12'hA00};
        run("fault a", 3);
        {clr, off_a, dmax} = {1'b1, 24'h800008};
        @(negedge clock_i) clr = 1'b0;
        run("mismatch", 3);
        {clr, dmax, amax} = {1'b1, 44'hFFF00001000};
        @(negedge clock_i) clr = 1'b0;
        run("amplitude", 3);
        {clr, amax, off_b} = {1'b1, 44'h7FFFFFFF600};
        @(negedge clock_i) clr = 1'b0;
        run("fault b", 3);
        limp_en = 1'b0;
        run("limp off", 2);
        `CHK(q.size(), 0)
        conclude();
    end
endmodule : srr_readout_tb
